/* File: gauge_defines.svh */
// constants shared by both ends of the gauge mode sequencer link
// assumes a single 50 MHz clock on both ends
`ifndef GAUGE_DEFINES_SVH
`define GAUGE_DEFINES_SVH

// ==========================================================
// timing
`define GAUGE_CLK_HZ 50000000
`define GAUGE_HOLD_MS 2000
`define GAUGE_HOLD_CYC ((`GAUGE_HOLD_MS / 1000) * `GAUGE_CLK_HZ)

// ==========================================================
// command words, same layout as the fieldbus third output word
`define CMD_W 16
`define CMD_HEAT_LOSS_ONLY 16'h0002
`define CMD_CORRECT_VALUE 16'h4002
`define CMD_RETURN_AUTO 16'h0009

// ==========================================================
// control input pair codes {correct, mode_select}
`define CTL_NONE 2'b00
`define CTL_MODE 2'b01
`define CTL_CORR 2'b10
`define CTL_BOTH 2'b11

// ==========================================================
// host register map, byte addresses
`define HREG_CMD 8'h00
`define HREG_PINS 8'h04
`define HREG_STATUS 8'h08
`define PIN_EN_BIT 0
`define PIN_MODE_BIT 1
`define PIN_CORR_BIT 2
`define ST_BUSY_BIT 0
`define ST_HLO_BIT 1
`define ST_CORR_BIT 2
`define ST_ACK_BIT 3

`endif

/* File: gauge_pkg.sv */
// types for the gauge mode sequencer
// assumes gauge_defines.svh is on the include path
`include "gauge_defines.svh"

package gauge_pkg;

    // ==========================================================
    // sequencer states
    typedef enum logic [1:0] {
        ST_AUTO,
        ST_CHECK,
        ST_CORRECT,
        ST_STORED
    } seq_state_t;

    typedef logic [`CMD_W-1:0] cmd_word_t;
    typedef logic [1:0] ctl_pair_t;

endpackage

/* File: gauge_link_if.sv */
// link between the gauge sequencer and its controlling host
// assumes both ends share one clock; pins are plain levels
`timescale 1ns/10ps
`include "gauge_defines.svh"

interface gauge_link_if;
    logic cmd_valid;
    logic [`CMD_W-1:0] cmd_word;
    logic cmd_ack;
    logic ext_enable;
    logic ctrl_mode;
    logic ctrl_corr;
    logic heat_loss_only;
    logic correcting;

    modport dev (
        input cmd_valid,
        input cmd_word,
        input ext_enable,
        input ctrl_mode,
        input ctrl_corr,
        output cmd_ack,
        output heat_loss_only,
        output correcting
    );

    modport host (
        output cmd_valid,
        output cmd_word,
        output ext_enable,
        output ctrl_mode,
        output ctrl_corr,
        input cmd_ack,
        input heat_loss_only,
        input correcting
    );
endinterface

/* File: gauge_seq_dev.sv */
// gauge end: mode and heat-loss calibration sequencer
// assumes link pins may be asynchronous; user inputs share core_clk_i
//
// Function
// [R1] first heat-loss command enters check step
// [R2] correct command starts automatic value correction
// [R3] second heat-loss command stores corrected full scale
// [R4] return command restores auto range, auto filament
// [R5] zero point uses same order at low pressure
// [R6] zero sequence stores zero point, not full scale
// [R7] serial command word equals fieldbus third word
// [R8] control input changes ignored while enable low
// [R9] steps held under hold time are rejected
// [R10] mode then both inputs corrects full scale
// [R11] release correct stores; release mode returns auto
// [R12] mode only to correct only corrects zero
// [R13] correct back to mode stores zero point
// [R14] auto range switches branches at switch point
// [R15] heat-loss mode never selects ionisation branch
// [R16] heat-loss mode drives status indicator red
// [R17] filament one first, two on fault
// [R18] synchronise and hold-qualify control inputs
// [R19] correction ignored unless check step done
`timescale 1ns/10ps
`include "gauge_defines.svh"

module gauge_seq_dev
    import gauge_pkg::*;
#(
    parameter int unsigned HOLD_CYC = `GAUGE_HOLD_CYC
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    gauge_link_if.dev link,
    input wire logic low_pressure_i,
    input wire logic below_switch_point_i,
    input wire logic fil1_fault_i,
    output logic heat_loss_only_o,
    output logic ion_branch_o,
    output logic filament2_o,
    output logic led_red_o,
    output logic led_green_o,
    output logic correcting_o,
    output logic store_full_scale_o,
    output logic store_zero_o
);

    localparam int unsigned CNT_W = $clog2(HOLD_CYC + 1);
    localparam int unsigned NPIN = 3;

    // ==========================================================
    // pin synchronisers
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_lvl;

    assign pin_raw = {link.ctrl_corr, link.ctrl_mode, link.ext_enable};

    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_sync
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            // level moves only when second and third stage agree, see [R18]
            always_ff @(posedge core_clk_i) begin
                if (srst_i) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    s1_q <= pin_raw[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign pin_lvl[i] = lvl_q;
        end
    endgenerate

    logic en_lvl;
    ctl_pair_t ctl_lvl;

    assign en_lvl = pin_lvl[`PIN_EN_BIT];
    assign ctl_lvl = {pin_lvl[`PIN_CORR_BIT], pin_lvl[`PIN_MODE_BIT]};

    // ==========================================================
    // hold-time qualifier
    ctl_pair_t cand_q;
    ctl_pair_t acc_q;
    ctl_pair_t from_q;
    logic [CNT_W-1:0] hold_cnt_q;
    logic step_q;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cand_q <= `CTL_NONE;
            acc_q <= `CTL_NONE;
            from_q <= `CTL_NONE;
            hold_cnt_q <= '0;
            step_q <= 1'b0;
        end else begin
            step_q <= 1'b0;
            if (ctl_lvl != cand_q) begin
                // a new level restarts the count; short steps die here, see [R9]
                cand_q <= ctl_lvl;
                hold_cnt_q <= '0;
            end else if (cand_q != acc_q) begin
                if (hold_cnt_q == CNT_W'(HOLD_CYC)) begin
                    acc_q <= cand_q;
                    from_q <= acc_q;
                    hold_cnt_q <= '0;
                    // disabled inputs are tracked but never acted on, see [R8]
                    step_q <= en_lvl;
                end else begin
                    hold_cnt_q <= hold_cnt_q + 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // command intake
    logic ack_q;
    logic cmd_take;
    logic cmd_hlo;
    logic cmd_corr;
    logic cmd_ret;

    assign cmd_take = link.cmd_valid && !ack_q;
    // one word decode serves serial and fieldbus alike, see [R7]
    assign cmd_hlo = cmd_take && (link.cmd_word == `CMD_HEAT_LOSS_ONLY);
    assign cmd_corr = cmd_take && (link.cmd_word == `CMD_CORRECT_VALUE);
    assign cmd_ret = cmd_take && (link.cmd_word == `CMD_RETURN_AUTO);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cmd_take;
        end
    end

    assign link.cmd_ack = ack_q;

    // ==========================================================
    // step decode
    logic st_enter;
    logic st_full;
    logic st_zero;
    logic st_store_full;
    logic st_store_zero;
    logic st_release;

    assign st_enter = step_q && (from_q == `CTL_NONE) && (acc_q == `CTL_MODE);
    assign st_full = step_q && (from_q == `CTL_MODE) && (acc_q == `CTL_BOTH);
    assign st_zero = step_q && (from_q == `CTL_MODE) && (acc_q == `CTL_CORR);
    assign st_store_full = step_q && (from_q == `CTL_BOTH) && (acc_q == `CTL_MODE);
    assign st_store_zero = step_q && (from_q == `CTL_CORR) && (acc_q == `CTL_MODE);
    assign st_release = step_q && (acc_q == `CTL_NONE);

    // ==========================================================
    // sequencer
    seq_state_t state_q;
    logic zero_q;
    logic store_full_q;
    logic store_zero_q;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_q <= ST_AUTO;
            zero_q <= 1'b0;
            store_full_q <= 1'b0;
            store_zero_q <= 1'b0;
        end else begin
            store_full_q <= 1'b0;
            store_zero_q <= 1'b0;
            if (cmd_ret || st_release) begin
                // closing step from any state, see [R4] [R11] [R13]
                state_q <= ST_AUTO;
            end else begin
                unique case (state_q)
                    ST_AUTO: begin
                        if (cmd_hlo || st_enter) begin
                            state_q <= ST_CHECK; // see [R1] [R10]
                        end
                    end
                    ST_CHECK: begin
                        if (cmd_corr) begin
                            state_q <= ST_CORRECT; // see [R2] [R5]
                            zero_q <= low_pressure_i;
                        end else if (st_full) begin
                            state_q <= ST_CORRECT; // see [R10]
                            zero_q <= 1'b0;
                        end else if (st_zero) begin
                            state_q <= ST_CORRECT; // see [R12]
                            zero_q <= 1'b1;
                        end
                    end
                    ST_CORRECT: begin
                        if (cmd_hlo) begin
                            state_q <= ST_STORED; // see [R3] [R6]
                            store_full_q <= !zero_q;
                            store_zero_q <= zero_q;
                        end else if (st_store_full && !zero_q) begin
                            state_q <= ST_STORED; // see [R11]
                            store_full_q <= 1'b1;
                        end else if (st_store_zero && zero_q) begin
                            state_q <= ST_STORED; // see [R13]
                            store_zero_q <= 1'b1;
                        end
                    end
                    ST_STORED: begin
                        // a repeated heat-loss command keeps the stored value
                        state_q <= ST_STORED;
                    end
                endcase
            end
            // correct commands outside check fall through untouched, see [R19]
        end
    end

    // ==========================================================
    // outputs
    logic hlo_q;
    logic ion_q;
    logic fil2_q;
    logic red_q;
    logic green_q;
    logic corr_q;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            hlo_q <= 1'b0;
            ion_q <= 1'b0;
            fil2_q <= 1'b0;
            red_q <= 1'b0;
            green_q <= 1'b0;
            corr_q <= 1'b0;
        end else begin
            hlo_q <= (state_q != ST_AUTO);
            // ionisation only in auto range below switch point, see [R14] [R15]
            ion_q <= (state_q == ST_AUTO) && below_switch_point_i;
            fil2_q <= fil1_fault_i; // see [R17]
            red_q <= (state_q != ST_AUTO); // see [R16]
            green_q <= (state_q == ST_AUTO) && below_switch_point_i;
            corr_q <= (state_q == ST_CORRECT);
        end
    end

    assign heat_loss_only_o = hlo_q;
    assign ion_branch_o = ion_q;
    assign filament2_o = fil2_q;
    assign led_red_o = red_q;
    assign led_green_o = green_q;
    assign correcting_o = corr_q;
    assign store_full_scale_o = store_full_q;
    assign store_zero_o = store_zero_q;
    assign link.heat_loss_only = hlo_q;
    assign link.correcting = corr_q;

endmodule

/* File: gauge_seq_host.sv */
// host end: classic wishbone slave turning register writes into link traffic
// assumes the gauge end shares core_clk_i
`timescale 1ns/10ps
`include "gauge_defines.svh"

module gauge_seq_host
    import gauge_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    gauge_link_if.host link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    logic ack_q;
    logic [31:0] dat_q;
    logic acc;
    logic wr;

    assign acc = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = acc && wb_we_i;

    // ==========================================================
    // command channel, held until the gauge acknowledges
    logic valid_q;
    cmd_word_t word_q;
    logic acked_q;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            valid_q <= 1'b0;
            word_q <= '0;
            acked_q <= 1'b0;
        end else begin
            if (valid_q && link.cmd_ack) begin
                valid_q <= 1'b0;
                acked_q <= 1'b1;
            end else if (wr && wb_adr_i == `HREG_CMD && !valid_q && (&wb_sel_i[1:0])) begin
                // one word for serial or fieldbus, see [R7]
                valid_q <= 1'b1;
                word_q <= wb_dat_i[`CMD_W-1:0];
                acked_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // control pins; software spaces steps beyond the hold time, see [R9]
    logic [2:0] pins_q;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pins_q <= 3'h0;
        end else if (wr && wb_adr_i == `HREG_PINS && wb_sel_i[0]) begin
            pins_q <= wb_dat_i[2:0];
        end
    end

    // ==========================================================
    // bus answer
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            dat_q <= 32'h0000_0000;
            if (acc && !wb_we_i) begin
                unique case (wb_adr_i)
                    `HREG_CMD: dat_q <= {16'h0000, word_q};
                    `HREG_PINS: dat_q <= {29'h0, pins_q};
                    `HREG_STATUS: dat_q <= {28'h0, acked_q, link.correcting,
                                            link.heat_loss_only, valid_q};
                    default: dat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign link.cmd_valid = valid_q;
    assign link.cmd_word = word_q;
    assign link.ext_enable = pins_q[`PIN_EN_BIT];
    assign link.ctrl_mode = pins_q[`PIN_MODE_BIT];
    assign link.ctrl_corr = pins_q[`PIN_CORR_BIT];

endmodule

/* File: gauge_link_properties.sv */
// assertions on the gauge link between host end and gauge end
// assumes one clock for both ends and a synchronous active-high reset
`timescale 1ns/10ps
`include "gauge_defines.svh"

module gauge_link_properties #(
    parameter int unsigned HOLD_CYC = `GAUGE_HOLD_CYC
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic cmd_valid,
    input wire logic [`CMD_W-1:0] cmd_word,
    input wire logic cmd_ack,
    input wire logic ext_enable,
    input wire logic ctrl_mode,
    input wire logic ctrl_corr,
    input wire logic heat_loss_only,
    input wire logic correcting
);
    // ==========
    // helper counters: pin pair age, cycles since last command ack
    logic [1:0] pair_q;
    logic [31:0] still_q;
    logic [3:0] age_q;
    logic pin_go;

    always_ff @(posedge core_clk_i) begin
        pair_q <= {ctrl_corr, ctrl_mode};
        if (srst_i || pair_q != {ctrl_corr, ctrl_mode}) still_q <= '0;
        else if (still_q != '1) still_q <= still_q + 32'h1;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i || cmd_ack) age_q <= '0;
        else if (age_q != 4'hF) age_q <= age_q + 4'h1;
    end

    // pin-driven change: no command acked just before
    assign pin_go = (age_q > 4'h5);

    // ==========
    // properties
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    a_ack_single: assert property (cmd_ack |=> !cmd_ack)
        else $error("command ack longer than one cycle");
    a_ack_prompt: assert property (
        cmd_valid && !cmd_ack |=> cmd_ack && cmd_valid && $stable(cmd_word))
        else $error("command not acked or not held");
    a_ack_cause: assert property ($rose(cmd_ack) |-> $past(cmd_valid))
        else $error("ack without pending command");
    a_hlo_enter: assert property (
        cmd_valid && !cmd_ack && cmd_word == `CMD_HEAT_LOSS_ONLY |-> ##[1:3] heat_loss_only)
        else $error("heat-loss command did not enter heat-loss mode");
    a_auto_return: assert property (
        cmd_valid && !cmd_ack && cmd_word == `CMD_RETURN_AUTO |-> ##[1:3] !heat_loss_only)
        else $error("return command did not restore auto mode");
    a_corr_in_hlo: assert property (correcting |-> heat_loss_only)
        else $error("correcting outside heat-loss mode");
    a_corr_cause: assert property ($rose(correcting) |-> $past(heat_loss_only))
        else $error("correction started without check step");
    a_pin_hold: assert property (
        $rose(heat_loss_only) && pin_go |->
        still_q >= HOLD_CYC && ext_enable && ctrl_mode && !ctrl_corr)
        else $error("mode pin step accepted too early or unenabled");
    a_pin_corr: assert property (
        $rose(correcting) && pin_go |-> still_q >= HOLD_CYC && ext_enable && ctrl_corr)
        else $error("correct pin step accepted too early");
    a_pin_release: assert property (
        $fell(heat_loss_only) && pin_go |-> !ctrl_mode && !ctrl_corr)
        else $error("auto mode left pins not released");

    c_ack: cover property (cmd_ack);
    c_corr: cover property ($rose(correcting));
    c_pin_auto: cover property ($fell(heat_loss_only) && pin_go);
endmodule

/* File: tb_gauge_calibration_mode_sequencer.sv */
// self-checking bench for both ends of the gauge link
// assumes a hold count of 20 cycles and a 50 MHz clock
`timescale 1ns/10ps
`include "gauge_defines.svh"

module tb_gauge_calibration_mode_sequencer
    import gauge_pkg::*;
;
    localparam int unsigned HOLD = 20;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic low_p = 1'b0;
    logic below_sp = 1'b1;
    logic fil_fault = 1'b0;
    logic hlo_o, ion_o, fil2_o, red_o, green_o, corr_o, sfs_o, szr_o;
    cmd_word_t last_word = '0;
    int fs_n = 0;
    int zr_n = 0;
    int exp_fs = 0;
    int exp_zr = 0;
    int error_cnt = 0;
    int num_checks = 0;

    always #10 core_clk_i = ~core_clk_i;

    gauge_link_if link_bus ();
    gauge_seq_dev #(.HOLD_CYC(HOLD)) i_gauge_seq_dev (.core_clk_i(core_clk_i),
        .srst_i(srst_i), .link(link_bus), .low_pressure_i(low_p),
        .below_switch_point_i(below_sp), .fil1_fault_i(fil_fault),
        .heat_loss_only_o(hlo_o), .ion_branch_o(ion_o), .filament2_o(fil2_o),
        .led_red_o(red_o), .led_green_o(green_o), .correcting_o(corr_o),
        .store_full_scale_o(sfs_o), .store_zero_o(szr_o));
    gauge_seq_host i_gauge_seq_host (.core_clk_i(core_clk_i), .srst_i(srst_i),
        .link(link_bus), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack));
    gauge_link_properties #(.HOLD_CYC(HOLD)) i_gauge_link_properties (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .cmd_valid(link_bus.cmd_valid),
        .cmd_word(link_bus.cmd_word), .cmd_ack(link_bus.cmd_ack),
        .ext_enable(link_bus.ext_enable), .ctrl_mode(link_bus.ctrl_mode),
        .ctrl_corr(link_bus.ctrl_corr), .heat_loss_only(link_bus.heat_loss_only),
        .correcting(link_bus.correcting));

    // ==========
    // store pulse counters, last command seen on the link
    always @(posedge core_clk_i) begin
        if (sfs_o === 1'b1) fs_n++;
        if (szr_o === 1'b1) zr_n++;
        if (link_bus.cmd_valid && link_bus.cmd_ack) last_word <= link_bus.cmd_word;
    end

    // ==========
    // shared tasks
    task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
            output logic [31:0] rd);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        // waits for the slave ack; the watchdog ends it only if no ack comes
        do begin
            @(posedge core_clk_i);
        end while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge core_clk_i);
        // slave drops ack the cycle after it gave it
        check_eq(wb_ack, 1'b0);
    endtask

    task automatic send_cmd(input cmd_word_t code, input logic h, input logic c);
        logic [31:0] st;
        wb_xfer(1'b1, `HREG_CMD, {16'h0, code}, st);
        repeat (4) @(posedge core_clk_i);
        check_eq(last_word, code);
        wb_xfer(1'b0, `HREG_STATUS, 32'h0, st);
        check_eq(st[3:0], {1'b1, c, h, 1'b0});
    endtask

    task automatic set_pins(input logic en, input logic m, input logic c);
        logic [31:0] st;
        wb_xfer(1'b1, `HREG_PINS, {29'h0, c, m, en}, st);
    endtask

    task automatic wait_out(input logic h, input logic c);
        int n;
        n = 0;
        while (!(hlo_o === h && corr_o === c) && n < 4 * HOLD) begin
            @(posedge core_clk_i);
            n++;
        end
        repeat (2) @(posedge core_clk_i);
        check_eq({hlo_o, corr_o}, {h, c});
    endtask

    // ==========
    // scenarios
    task automatic t_reset_map();
        logic [31:0] rd;
        wb_xfer(1'b0, `HREG_STATUS, 32'h0, rd);
        check_eq(rd, 32'h0);
        wb_xfer(1'b1, 8'h0C, 32'hFFFF, rd);
        wb_xfer(1'b0, 8'h0C, 32'h0, rd);
        check_eq(rd, 32'h0);
        check_eq({hlo_o, red_o, ion_o, green_o}, 4'h3);
        below_sp <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        check_eq({ion_o, green_o}, 2'h0);
        below_sp <= 1'b1;
        fil_fault <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        check_eq(fil2_o, 1'b1);
        check_eq({ion_o, green_o}, 2'h3);
        fil_fault <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        check_eq(fil2_o, 1'b0);
    endtask

    task automatic t_refused();
        send_cmd(`CMD_CORRECT_VALUE, 1'b0, 1'b0);
        send_cmd(16'h1234, 1'b0, 1'b0);
    endtask

    task automatic t_cmd_cal(input logic zp);
        low_p <= zp;
        send_cmd(`CMD_HEAT_LOSS_ONLY, 1'b1, 1'b0);
        check_eq({ion_o, red_o}, 2'b01);
        send_cmd(`CMD_CORRECT_VALUE, 1'b1, 1'b1);
        send_cmd(`CMD_HEAT_LOSS_ONLY, 1'b1, 1'b0);
        if (zp) exp_zr++;
        else exp_fs++;
        check_eq(fs_n, exp_fs);
        check_eq(zr_n, exp_zr);
        send_cmd(`CMD_RETURN_AUTO, 1'b0, 1'b0);
        check_eq({ion_o, red_o}, 2'b10);
    endtask

    task automatic t_pin_cal(input logic zp);
        set_pins(1'b1, 1'b1, 1'b0);
        wait_out(1'b1, 1'b0);
        set_pins(1'b1, !zp, 1'b1);
        wait_out(1'b1, 1'b1);
        set_pins(1'b1, 1'b1, 1'b0);
        wait_out(1'b1, 1'b0);
        if (zp) exp_zr++;
        else exp_fs++;
        check_eq(fs_n, exp_fs);
        check_eq(zr_n, exp_zr);
        set_pins(1'b1, 1'b0, 1'b0);
        wait_out(1'b0, 1'b0);
    endtask

    task automatic t_short_step();
        set_pins(1'b1, 1'b1, 1'b0);
        repeat (HOLD / 2) @(posedge core_clk_i);
        check_eq(hlo_o, 1'b0);
        set_pins(1'b1, 1'b0, 1'b0);
        repeat (3 * HOLD) @(posedge core_clk_i);
        check_eq(hlo_o, 1'b0);
    endtask

    task automatic t_enable_low();
        set_pins(1'b0, 1'b1, 1'b0);
        repeat (3 * HOLD) @(posedge core_clk_i);
        check_eq(hlo_o, 1'b0);
        set_pins(1'b0, 1'b0, 1'b0);
        repeat (3 * HOLD) @(posedge core_clk_i);
    endtask

    // ==========
    // verdict, sequence, watchdog
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        t_reset_map();
        t_refused();
        t_cmd_cal(1'b0);
        t_cmd_cal(1'b1);
        t_short_step();
        t_enable_low();
        t_pin_cal(1'b0);
        t_pin_cal(1'b1);
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        error_cnt++;
        complete_run();
    end
endmodule
